/* hw/qbs_burst_mem.sv */
`timescale 1ns/100ps
module qbs_burst_mem #(
  parameter int ADDR_W = qbs_pkg::ADDR_W_DEF,
  parameter int LANES  = 4,
  parameter int LANE_W = qbs_pkg::LANE_W
) (
  // Clock
  input  wire logic                      clk_sys,
  // Write port
  input  wire logic                      wrEn,
  input  wire logic [ADDR_W-1:0]         wrAddr,
  input  wire logic [LANES*LANE_W-1:0]   wrData,
  input  wire logic [LANES-1:0]          wrLaneEn,
  // Read port
  input  wire logic                      rdEn,
  input  wire logic [ADDR_W-1:0]         rdAddr,
  output logic      [LANES*LANE_W-1:0]   rdData
);
  import qbs_pkg::*;

  logic [LANES*LANE_W-1:0] store [0:(1<<ADDR_W)-1];

  // ----------------------------------------------------------------
  // Ports are independent, so a read and a write may share a cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < LANES; i++) begin
      if (wrEn && wrLaneEn[i]) begin
        store[wrAddr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rdEn) begin
      rdData <= store[rdAddr];
    end
  end

endmodule // qbs_burst_mem

/* hw/qbs_pkg.sv */
package qbs_pkg;

  // ----------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------
  localparam int LANE_W       = 9;
  localparam int DATA_W_DEF   = 18;
  localparam int ADDR_W_DEF   = 19;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 8;
  localparam int CAL_INTERVAL_US  = 20;
  localparam int CAL_CYCLES       = CAL_INTERVAL_US * 1000 / CLK_PERIOD_NS;
  localparam int CAL_CNT_W        = 12;
  // Both output clocks high one cycle longer than this selects single clock mode
  localparam int SINGLE_HOLD_CYCLES = 16;
  localparam int HOLD_CNT_W         = 5;

  // ----------------------------------------------------------------
  // Pin groups and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic kPos;
    logic kNeg;
    logic cPos;
    logic cNeg;
    logic rdN;
    logic wrN;
    logic pllBypassN;
  } qbs_ctl_s;

  // Clock pins at idle levels, strobes idle, PLL in use
  localparam qbs_ctl_s CTL_RST = 7'h2F;

  typedef enum logic [1:0] {
    LS_IDLE   = 2'b00,
    LS_FIRST  = 2'b01,
    LS_SECOND = 2'b10
  } qbs_launch_e;

endpackage

/* hw/qbs_sram_port.sv */
`timescale 1ns/100ps
module qbs_sram_port #(
  parameter int DATA_W = qbs_pkg::DATA_W_DEF,
  parameter int ADDR_W = qbs_pkg::ADDR_W_DEF,
  parameter int LANES  = DATA_W / qbs_pkg::LANE_W
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Link clocks
  input  wire logic              in_timing_pos,
  input  wire logic              in_timing_neg,
  input  wire logic              out_timing_pos,
  input  wire logic              out_timing_neg,
  // Command and write data
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic [DATA_W-1:0] write_data_in,
  input  wire logic [LANES-1:0]  byte_lane_write_n,
  // Read data and echo
  output logic      [DATA_W-1:0] read_data_out,
  output logic                   read_data_oe_n,
  output logic                   echo_timing_pos,
  output logic                   echo_timing_neg,
  // Housekeeping
  input  wire logic              pll_bypass_n,
  output logic                   impedanceCalPulse,
  output logic                   pllBypassed
);
  import qbs_pkg::*;

  localparam int BW = 2 * DATA_W;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  qbs_ctl_s              ctlS1Reg, ctlS2Reg, ctlPrevReg;
  logic [ADDR_W-1:0]     addrS1Reg, addrS2Reg;
  logic [DATA_W-1:0]     dinS1Reg, dinS2Reg;
  logic [LANES-1:0]      laneS1Reg, laneS2Reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctlS1Reg   <= CTL_RST;
      ctlS2Reg   <= CTL_RST;
      ctlPrevReg <= CTL_RST;
      addrS1Reg  <= '0;
      addrS2Reg  <= '0;
      dinS1Reg   <= '0;
      dinS2Reg   <= '0;
      laneS1Reg  <= '1;
      laneS2Reg  <= '1;
    end else begin
      ctlS1Reg   <= '{in_timing_pos, in_timing_neg, out_timing_pos,
                      out_timing_neg, read_strobe_n, write_strobe_n,
                      pll_bypass_n};
      ctlS2Reg   <= ctlS1Reg;
      ctlPrevReg <= ctlS2Reg;
      addrS1Reg  <= address;
      addrS2Reg  <= addrS1Reg;
      dinS1Reg   <= write_data_in;
      dinS2Reg   <= dinS1Reg;
      laneS1Reg  <= byte_lane_write_n;
      laneS2Reg  <= laneS1Reg;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and clock mode
  // ----------------------------------------------------------------
  logic                  singleReg;
  logic [HOLD_CNT_W-1:0] hiCntReg;
  logic                  kPosEdge, kNegEdge, cPosEdge, cNegEdge;
  logic                  outPosEdge, outNegEdge, outPosLvl, outNegLvl;

  assign kPosEdge   = ctlS2Reg.kPos & ~ctlPrevReg.kPos;
  assign kNegEdge   = ctlS2Reg.kNeg & ~ctlPrevReg.kNeg;
  assign cPosEdge   = ctlS2Reg.cPos & ~ctlPrevReg.cPos;
  assign cNegEdge   = ctlS2Reg.cNeg & ~ctlPrevReg.cNeg;
  assign outPosEdge = singleReg ? kPosEdge : cPosEdge;
  assign outNegEdge = singleReg ? kNegEdge : cNegEdge;
  assign outPosLvl  = singleReg ? ctlS2Reg.kPos : ctlS2Reg.cPos;
  assign outNegLvl  = singleReg ? ctlS2Reg.kNeg : ctlS2Reg.cNeg;

  // Antiphase output clocks never sit high together for long
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hiCntReg  <= '0;
      singleReg <= 1'b0;
    end else if (ctlS2Reg.cPos && ctlS2Reg.cNeg) begin
      if (hiCntReg != HOLD_CNT_W'(SINGLE_HOLD_CYCLES)) begin
        hiCntReg <= hiCntReg + 1'b1;
      end
      singleReg <= (hiCntReg == HOLD_CNT_W'(SINGLE_HOLD_CYCLES));
    end else begin
      hiCntReg  <= '0;
      singleReg <= 1'b0;
    end
  end

  // Echo follows the selected timing pair, so it stops with it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      echo_timing_pos <= 1'b0;
      echo_timing_neg <= 1'b0;
    end else begin
      echo_timing_pos <= outPosLvl;
      echo_timing_neg <= outNegLvl;
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  logic                  wrArmedReg, memWeReg;
  logic [DATA_W-1:0]     wrLoReg;
  logic [LANES-1:0]      laneLoReg;
  logic [ADDR_W-1:0]     memWaddrReg;
  logic [BW-1:0]         memWdataReg;
  logic [2*LANES-1:0]    memBeReg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrArmedReg  <= 1'b0;
      memWeReg    <= 1'b0;
      wrLoReg     <= '0;
      laneLoReg   <= '1;
      memWaddrReg <= '0;
      memWdataReg <= '0;
      memBeReg    <= '0;
    end else begin
      memWeReg <= 1'b0;
      if (kPosEdge && !ctlS2Reg.wrN) begin
        wrArmedReg <= 1'b1;
        wrLoReg    <= dinS2Reg;
        laneLoReg  <= laneS2Reg;
      end else if (kNegEdge && wrArmedReg) begin
        wrArmedReg  <= 1'b0;
        memWeReg    <= 1'b1;
        memWaddrReg <= addrS2Reg;
        memWdataReg <= {dinS2Reg, wrLoReg};
        memBeReg    <= ~{laneS2Reg, laneLoReg};
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path with two-entry buffer
  // ----------------------------------------------------------------
  logic                  rdPendReg, inflightReg;
  logic [ADDR_W-1:0]     rdAddrReg;
  logic [BW-1:0]         memRdata;
  logic [BW-1:0]         fifoMem [0:1];
  logic                  fifoWpReg, fifoRpReg;
  logic [1:0]            fifoCntReg;
  logic                  fillReady, memRe, fifoValid, fifoPop;
  logic                  armedReg;
  qbs_launch_e           lStateReg;

  assign fillReady = (fifoCntReg != 2'h2) && !inflightReg;
  assign memRe     = rdPendReg && fillReady;
  assign fifoValid = (fifoCntReg != 2'h0);
  assign fifoPop   = outPosEdge && fifoValid && !armedReg &&
                     (lStateReg != LS_SECOND);

  // A read that finds one still waiting is dropped unless the waiting read issues in that cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdPendReg   <= 1'b0;
      rdAddrReg   <= '0;
      inflightReg <= 1'b0;
    end else begin
      inflightReg <= memRe;
      if (kPosEdge && !ctlS2Reg.rdN && (!rdPendReg || memRe)) begin
        rdPendReg <= 1'b1;
        rdAddrReg <= addrS2Reg;
      end else if (memRe) begin
        rdPendReg <= 1'b0;
      end
    end
  end

  qbs_burst_mem #(
    .ADDR_W (ADDR_W),
    .LANES  (2 * LANES),
    .LANE_W (LANE_W)
  ) u_mem (
    .clk_sys  (clk_sys),
    .wrEn     (memWeReg),
    .wrAddr   (memWaddrReg),
    .wrData   (memWdataReg),
    .wrLaneEn (memBeReg),
    .rdEn     (memRe),
    .rdAddr   (rdAddrReg),
    .rdData   (memRdata)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fifoWpReg  <= 1'b0;
      fifoRpReg  <= 1'b0;
      fifoCntReg <= 2'h0;
    end else begin
      if (inflightReg) begin
        fifoWpReg <= ~fifoWpReg;
      end
      if (fifoPop) begin
        fifoRpReg <= ~fifoRpReg;
      end
      fifoCntReg <= fifoCntReg + {1'b0, inflightReg} - {1'b0, fifoPop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (inflightReg) begin
      fifoMem[fifoWpReg] <= memRdata;
    end
  end

  // ----------------------------------------------------------------
  // Output launcher
  // ----------------------------------------------------------------
  logic [BW-1:0]         armDataReg;
  logic [DATA_W-1:0]     hiWordReg;

  // First out pos edge after the push is that of cycle t+1
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armedReg       <= 1'b0;
      armDataReg     <= '0;
      hiWordReg      <= '0;
      lStateReg      <= LS_IDLE;
      read_data_out  <= '0;
      read_data_oe_n <= 1'b1;
    end else begin
      if (fifoPop) begin
        armedReg   <= 1'b1;
        armDataReg <= fifoMem[fifoRpReg];
      end
      if (outNegEdge && armedReg) begin
        armedReg       <= 1'b0;
        read_data_out  <= armDataReg[DATA_W-1:0];
        hiWordReg      <= armDataReg[BW-1:DATA_W];
        read_data_oe_n <= 1'b0;
        lStateReg      <= LS_FIRST;
      end else if (outNegEdge && lStateReg == LS_SECOND) begin
        read_data_out  <= '0;
        read_data_oe_n <= 1'b1;
        lStateReg      <= LS_IDLE;
      end else if (outPosEdge && lStateReg == LS_FIRST) begin
        read_data_out  <= hiWordReg;
        lStateReg      <= LS_SECOND;
      end
    end
  end

  // ----------------------------------------------------------------
  // Impedance recalibration and PLL bypass
  // ----------------------------------------------------------------
  logic [CAL_CNT_W-1:0]  calCntReg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      calCntReg         <= '0;
      impedanceCalPulse <= 1'b0;
    end else if (calCntReg == CAL_CNT_W'(CAL_CYCLES - 1)) begin
      calCntReg         <= '0;
      impedanceCalPulse <= 1'b1;
    end else begin
      calCntReg         <= calCntReg + 1'b1;
      impedanceCalPulse <= 1'b0;
    end
  end

  // Sampled design has no PLL; bypass only reported for debug
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pllBypassed <= 1'b0;
    end else begin
      pllBypassed <= ~ctlS2Reg.pllBypassN;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  read_start_a: assert property (kPosEdge && !ctlS2Reg.rdN && !rdPendReg
    |=> rdPendReg && rdAddrReg == $past(addrS2Reg))
    else $error("read not registered");
  nop_ignore_a: assert property (kPosEdge && ctlS2Reg.rdN && ctlS2Reg.wrN
    && !wrArmedReg |=> $stable(rdAddrReg) && !wrArmedReg)
    else $error("address taken during no operation");
  write_start_a: assert property (kPosEdge && !ctlS2Reg.wrN
    |=> wrArmedReg && wrLoReg == $past(dinS2Reg))
    else $error("write not registered");
  write_addr_a: assert property (kNegEdge && wrArmedReg
    |=> memWeReg && memWaddrReg == $past(addrS2Reg))
    else $error("write address not taken on neg edge");
  write_once_a: assert property (memWeReg |=> !memWeReg ##1 !memWeReg)
    else $error("burst written more than once");
  both_cmds_a: assert property (kPosEdge && !ctlS2Reg.rdN
    && !ctlS2Reg.wrN && !rdPendReg |=> rdPendReg && wrArmedReg)
    else $error("concurrent read and write not both taken");
  first_word_a: assert property (outNegEdge && armedReg
    |=> !read_data_oe_n
    && read_data_out == $past(armDataReg[DATA_W-1:0]))
    else $error("first word not launched on neg edge");
  second_word_a: assert property (outPosEdge && lStateReg == LS_FIRST
    |=> read_data_out == $past(hiWordReg) && lStateReg == LS_SECOND)
    else $error("second word not launched on pos edge");
  idle_float_a: assert property (lStateReg == LS_IDLE
    |-> read_data_oe_n && read_data_out == '0)
    else $error("read data driven without a read");
  echo_track_a: assert property (outPosEdge && $stable(singleReg)
    |=> $rose(echo_timing_pos))
    else $error("echo not following timing clock");
  cal_period_a: assert property (impedanceCalPulse
    |-> calCntReg == '0
    && $past(calCntReg) == CAL_CNT_W'(CAL_CYCLES - 1))
    else $error("recalibration period wrong");

  read_burst_c:   cover property (lStateReg == LS_FIRST ##[1:16]
                                  lStateReg == LS_SECOND);
  write_burst_c:  cover property (memWeReg);
  concurrent_c:   cover property (kPosEdge && !ctlS2Reg.rdN &&
                                  !ctlS2Reg.wrN);
  single_mode_c:  cover property (singleReg && armedReg);
  back_to_back_c: cover property (fifoPop && lStateReg == LS_FIRST);

endmodule // qbs_sram_port

/* testbench/qbs_ctl_model.sv */
`timescale 1ns/100ps
module qbs_ctl_model #(
  parameter int DATA_W = qbs_pkg::DATA_W_DEF,
  parameter int ADDR_W = qbs_pkg::ADDR_W_DEF,
  parameter int LANES  = DATA_W / qbs_pkg::LANE_W
) (
  // System clock, for stimulus timing
  input  wire logic         clk_sys,
  // Link clocks
  output logic              in_timing_pos,
  output logic              in_timing_neg,
  output logic              out_timing_pos,
  output logic              out_timing_neg,
  // Command and write data
  output logic              read_strobe_n,
  output logic              write_strobe_n,
  output logic [ADDR_W-1:0] address,
  output logic [DATA_W-1:0] write_data_in,
  output logic [LANES-1:0]  byte_lane_write_n,
  // Read data
  input  wire logic [DATA_W-1:0] read_data_out,
  input  wire logic              read_data_oe_n
);
  import qbs_pkg::*;

  // 0 output pair follows input pair, 1 both held high, 2 stopped
  int unsigned         cMode = 0;
  logic [2*DATA_W-1:0] rxQ[$];
  logic [DATA_W-1:0]   firstWord;
  logic                haveFirst = 1'b0;
  wire                 selPos = (cMode == 1) ? in_timing_pos : out_timing_pos;
  wire                 selNeg = (cMode == 1) ? in_timing_neg : out_timing_neg;

  // ----------------------------------------------------------------
  // Clock and command drive
  // ----------------------------------------------------------------
  // Impedance resistor never changes, so no repeated power-on
  initial begin
    read_strobe_n     = 1'b1;
    write_strobe_n    = 1'b1;
    address           = '0;
    write_data_in     = '0;
    byte_lane_write_n = '1;
    in_timing_pos     = 1'b0;
    in_timing_neg     = 1'b1;
    out_timing_pos    = 1'b0;
    out_timing_neg    = 1'b1;
  end

  task automatic drive_clocks(input logic pos);
    in_timing_pos  <= pos;
    in_timing_neg  <= !pos;
    out_timing_pos <= (cMode == 1) | ((cMode == 0) & pos);
    out_timing_neg <= (cMode == 1) | ((cMode == 0) & !pos);
  endtask

  // One input period of eight system clocks, begun on a clock edge
  task automatic link_cycle(input logic rd, input logic wr,
                            input logic [ADDR_W-1:0]   rdAddr,
                            input logic [ADDR_W-1:0]   wrAddr,
                            input logic [2*DATA_W-1:0] burst,
                            input logic [2*LANES-1:0]  maskN);
    read_strobe_n     <= !rd;
    write_strobe_n    <= !wr;
    address           <= rdAddr;
    write_data_in     <= wr ? burst[DATA_W-1:0] : ~write_data_in;
    byte_lane_write_n <= maskN[LANES-1:0];
    @(posedge clk_sys);
    drive_clocks(1'b1);
    repeat (3) @(posedge clk_sys);
    address           <= wrAddr;
    write_data_in     <= wr ? burst[2*DATA_W-1:DATA_W] : ~write_data_in;
    byte_lane_write_n <= maskN[2*LANES-1:LANES];
    @(posedge clk_sys);
    drive_clocks(1'b0);
    repeat (3) @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  // Sampled mid-word, on system clock falling edges
  always @(posedge selNeg) begin
    #36;
    haveFirst = (read_data_oe_n === 1'b0);
    firstWord = read_data_out;
  end

  always @(posedge selPos) begin
    #36;
    if (haveFirst && read_data_oe_n === 1'b0)
      rxQ.push_back({read_data_out, firstWord});
    haveFirst = 1'b0;
  end
endmodule // qbs_ctl_model

/* testbench/quad_rate_burst2_sram_port_test.sv */
`timescale 1ns/100ps
module quad_rate_burst2_sram_port_test;
  import qbs_pkg::*;
  localparam int DW = DATA_W_DEF;
  localparam int AW = ADDR_W_DEF;
  localparam int LN = DW / LANE_W;

  logic          clk_sys;
  logic          rst_n;
  logic          pll_bypass_n;
  wire           in_timing_pos, in_timing_neg, out_timing_pos, out_timing_neg;
  wire           read_strobe_n, write_strobe_n;
  wire [AW-1:0]  address;
  wire [DW-1:0]  write_data_in;
  wire [LN-1:0]  byte_lane_write_n;
  wire [DW-1:0]  read_data_out;
  wire           read_data_oe_n, echo_timing_pos, echo_timing_neg;
  wire           impedanceCalPulse, pllBypassed;
  int            errors = 0;
  int            numChecks = 0;
  int            cyc = 0;
  int            lastCal = 0;
  int            calGap = 0;
  int            calCount = 0;
  int            echoPos = 0;
  int            echoNeg = 0;
  int            ra;
  logic [31:0]   seedVal;
  logic [2*DW-1:0] memModel[int];
  logic [2*DW-1:0] expQ[$];

  qbs_sram_port uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .in_timing_pos(in_timing_pos), .in_timing_neg(in_timing_neg),
    .out_timing_pos(out_timing_pos), .out_timing_neg(out_timing_neg),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .address(address), .write_data_in(write_data_in),
    .byte_lane_write_n(byte_lane_write_n), .read_data_out(read_data_out),
    .read_data_oe_n(read_data_oe_n), .echo_timing_pos(echo_timing_pos),
    .echo_timing_neg(echo_timing_neg), .pll_bypass_n(pll_bypass_n),
    .impedanceCalPulse(impedanceCalPulse), .pllBypassed(pllBypassed));

  qbs_ctl_model ctl (.clk_sys(clk_sys), .in_timing_pos(in_timing_pos),
    .in_timing_neg(in_timing_neg), .out_timing_pos(out_timing_pos),
    .out_timing_neg(out_timing_neg), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .address(address),
    .write_data_in(write_data_in), .byte_lane_write_n(byte_lane_write_n),
    .read_data_out(read_data_out), .read_data_oe_n(read_data_oe_n));

  // ----------------------------------------------------------------
  // Clock, monitors and checks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (impedanceCalPulse === 1'b1) begin
      calGap   <= cyc - lastCal;
      lastCal  <= cyc;
      calCount <= calCount + 1;
    end
  end

  always @(posedge echo_timing_pos) echoPos++;
  always @(posedge echo_timing_neg) echoNeg++;

  task automatic chk_data(input logic [2*DW-1:0] got,
                          input logic [2*DW-1:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %b", $time, what, got);
    end
  endtask

  task automatic chk_count(input int got, input int exp, input string what);
    numChecks++;
    if (got != exp) begin
      errors++;
      $display("MISMATCH at %0t: %s %0d not %0d", $time, what, got, exp);
    end
  endtask

  function automatic logic [2*DW-1:0] merge(input logic [2*DW-1:0] old,
      input logic [2*DW-1:0] nw, input logic [2*LN-1:0] maskN);
    logic [2*DW-1:0] r;
    r = old;
    for (int i = 0; i < 2*LN; i++)
      if (!maskN[i]) r[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
    return r;
  endfunction

  // Reads are predicted before a write of the same cycle lands
  task automatic op(input logic rd, input logic wr, input int rAddr,
                    input int wAddr, input logic [2*LN-1:0] maskN);
    logic [2*DW-1:0] burst;
    burst = (2*DW)'({$urandom, $urandom});
    if (rd) expQ.push_back(memModel[rAddr]);
    if (wr) memModel[wAddr] = merge(memModel[wAddr], burst, maskN);
    ctl.link_cycle(rd, wr, AW'(rAddr), AW'(wAddr), burst, maskN);
  endtask

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, $urandom_range(15), $urandom_range(15), '0);
  endtask

  task automatic traffic(input int n);
    repeat (n) begin
      ra = $urandom_range(15);
      op(1'($urandom), 1'($urandom), ra, (ra + 1 + $urandom_range(14)) % 16,
         (2*LN)'($urandom));
    end
    idle(6);
    chk_count(ctl.rxQ.size(), expQ.size(), "burst count");
    while (ctl.rxQ.size() > 0 && expQ.size() > 0)
      chk_data(ctl.rxQ.pop_front(), expQ.pop_front(), "read burst");
    ctl.rxQ.delete();
    expQ.delete();
    chk_flag(read_data_oe_n, 1'b1, "idle enable");
    chk_data(read_data_out, '0, "idle data");
  endtask

  // Counts are cleared and read on falling clock edges, away from echo updates
  task automatic echo_count(input int exp);
    idle(4);
    #4;
    echoPos = 0;
    echoNeg = 0;
    @(posedge clk_sys);
    idle(10);
    #4;
    chk_count(echoPos, exp, "echo pos");
    chk_count(echoNeg, exp, "echo neg");
    @(posedge clk_sys);
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seedVal      = $urandom(32'h4C13);
    rst_n        = 1'b0;
    pll_bypass_n = 1'b1;
    for (int a = 0; a < 16; a++) memModel[a] = '0;
    repeat (4) @(posedge clk_sys);
    chk_flag(read_data_oe_n, 1'b1, "reset enable");
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    idle(700);
    chk_count(calGap, CAL_CYCLES, "cal interval");
    chk_flag(calCount >= 2, 1'b1, "cal pulses");
    echo_count(10);
    for (int a = 0; a < 16; a++) op(1'b0, 1'b1, 0, a, '0);
    op(1'b1, 1'b1, 3, 5, '1);
    op(1'b1, 1'b1, 5, 3, 4'hA);
    op(1'b1, 1'b0, 5, 0, '0);
    traffic(150);
    ctl.cMode = 1;
    echo_count(10);
    traffic(40);
    ctl.cMode = 2;
    echo_count(0);
    ctl.cMode = 0;
    idle(4);
    @(posedge clk_sys);
    pll_bypass_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk_flag(pllBypassed, 1'b1, "bypass on");
    pll_bypass_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk_flag(pllBypassed, 1'b0, "bypass off");
    end_of_test();
  end
endmodule // quad_rate_burst2_sram_port_test
